// [dv/pafs_far_model.sv]
// far side model: package pins resolved from device drive and external sources
`timescale 1ns/1ps
module pafs_far_model (
  input wire logic [7:0] i_a_out,
  input wire logic [7:0] i_a_oe_b,
  input wire logic [7:0] i_a_ext,
  input wire logic [7:0] i_b_out,
  input wire logic [7:0] i_b_oe_b,
  input wire logic [7:0] i_b_ext,
  input wire logic [7:0] i_c_out,
  input wire logic [7:0] i_c_oe_b,
  input wire logic [7:0] i_c_ext,
  input wire logic i_d_out,
  input wire logic i_d_oe_b,
  input wire logic i_d_ext,
  output logic [7:0] o_a_pin,
  output logic [7:0] o_b_pin,
  output logic [7:0] o_c_pin,
  output logic o_d_pin
);
  // a pin the device releases takes the level of its external source
  assign o_a_pin = (i_a_oe_b & i_a_ext) | (~i_a_oe_b & i_a_out);
  assign o_b_pin = (i_b_oe_b & i_b_ext) | (~i_b_oe_b & i_b_out);
  assign o_c_pin = (i_c_oe_b & i_c_ext) | (~i_c_oe_b & i_c_out);
  assign o_d_pin = i_d_oe_b ? i_d_ext : i_d_out;
endmodule

// [dv/test_pafs_port_mux.sv]
// self-checking bench for the port alternate function selector
`timescale 1ns/1ps
module test_pafs_port_mux;
  logic clk, rst_b, psel, pen, pwr, xtal, t0o, t0c, t1o, t1c, de, tx, cmp, rdrv, d_ext;
  logic [7:0] paddr, a_ext, b_ext, c_ext, a_pin, b_pin, c_pin, a_out, a_oe, b_out, b_oe, c_out, c_oe, b_an, c_an;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, d_pin, d_out, d_oe, t0i, t1i, cts, rx, eclk, erst_b, vb5, vc2, xp;
  int error_cnt, n_compared;

  pafs_port_mux dut (.i_clock(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_port_a_pin(a_pin), .o_port_a_out(a_out), .o_port_a_oe_b(a_oe), .i_port_b_pin(b_pin),
    .o_port_b_out(b_out), .o_port_b_oe_b(b_oe), .i_port_c_pin(c_pin), .o_port_c_out(c_out),
    .o_port_c_oe_b(c_oe), .i_port_d_pin(d_pin), .o_port_d_out(d_out), .o_port_d_oe_b(d_oe),
    .i_crystal_enable(xtal), .i_timer_zero_output(t0o), .i_timer_zero_complement_mode(t0c),
    .i_timer_one_output(t1o), .i_timer_one_complement_mode(t1c), .i_uart_driver_enable(de),
    .i_uart_transmit(tx), .i_comparator_output(cmp), .i_reset_drive(rdrv), .o_timer_zero_input(t0i),
    .o_timer_one_input(t1i), .o_uart_clear_to_send(cts), .o_uart_receive(rx), .o_ext_clock_input(eclk),
    .o_ext_reset_b(erst_b), .o_port_b_analog(b_an), .o_port_c_analog(c_an), .o_vref_on_port_b5(vb5),
    .o_vref_on_port_c2(vc2), .o_crystal_pins(xp));

  pafs_far_model far (.i_a_out(a_out), .i_a_oe_b(a_oe), .i_a_ext(a_ext), .i_b_out(b_out), .i_b_oe_b(b_oe),
    .i_b_ext(b_ext), .i_c_out(c_out), .i_c_oe_b(c_oe), .i_c_ext(c_ext), .i_d_out(d_out), .i_d_oe_b(d_oe),
    .i_d_ext(d_ext), .o_a_pin(a_pin), .o_b_pin(b_pin), .o_c_pin(c_pin), .o_d_pin(d_pin));

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      error_cnt++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask

  // pins reach peripheral inputs three cycles late
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  // ***************************************************************
  // clock, reset, watchdog
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #(20 * 3000);
    error_cnt++;
    summarize();
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    error_cnt = 0;
    n_compared = 0;
    {rst_b, psel, pen, pwr, xtal, t0o, t0c, t1o, t1c, de, tx, cmp, rdrv, d_ext} = '0;
    {paddr, pwdata, a_ext, b_ext, c_ext} = '0;
    rdrv = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(pafs_pkg::OFS_A_DIR, 32'hff, 1'b0);
    rd(pafs_pkg::OFS_D_ALT, 32'h1, 1'b0);
    rd(pafs_pkg::OFS_CONFIG, 32'h2, 1'b0);
    rd(pafs_pkg::OFS_B_FSL, 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    settle();
    chk(d_oe, 1'b0);
    chk(erst_b, 1'b0);
    $display("reset test done");
    wr(pafs_pkg::OFS_A_DIR, 32'h0);
    wr(pafs_pkg::OFS_A_OUT, 32'h5a);
    settle();
    chk({a_out, a_oe}, 16'h5a00);
    {t0o, t1c, de} <= 3'b111;
    a_ext <= 8'h0b;
    wr(pafs_pkg::OFS_A_ALT, 32'hff);
    settle();
    chk(a_oe, 8'h19);
    chk(a_out & 8'he6, 8'h46);
    chk({t0i, cts, rx, t1i}, 4'b1100);
    t0c <= 1'b1;
    settle();
    chk({a_oe[0], a_out[0], t0i}, 3'b000);
    xtal <= 1'b1;
    settle();
    chk({a_oe[1:0], xp}, 3'b111);
    rd(pafs_pkg::OFS_CONFIG, 32'h6, 1'b0);
    xtal <= 1'b0;
    $display("port a test done");
    {b_ext, rdrv, d_ext} <= {8'h08, 2'b01};
    wr(pafs_pkg::OFS_B_FSL, 32'h0);
    wr(pafs_pkg::OFS_B_FSH, 32'hff);
    wr(pafs_pkg::OFS_B_ALT, 32'h08);
    settle();
    chk({eclk, b_an[3]}, 2'b10);
    chk({d_oe, erst_b}, 2'b11);
    rd(pafs_pkg::OFS_B_FSH, 32'hff, 1'b0);
    wr(pafs_pkg::OFS_B_FSL, 32'h08);
    settle();
    chk({eclk, b_an[3]}, 2'b01);
    rd(pafs_pkg::OFS_B_IN, 32'h08, 1'b0);
    wr(pafs_pkg::OFS_B_FSL, 32'h37);
    wr(pafs_pkg::OFS_B_ALT, 32'h3f);
    settle();
    chk({b_an, vb5}, 9'h06f);
    wr(pafs_pkg::OFS_B_DIR, 32'h0);
    wr(pafs_pkg::OFS_B_OUT, 32'hff);
    settle();
    chk({b_out, b_oe}, 16'hc03f);
    wr(pafs_pkg::OFS_B_FSL, 32'hc0);
    wr(pafs_pkg::OFS_B_ALT, 32'hff);
    settle();
    chk({b_out, b_oe, b_an, vb5}, 25'h001fe00);
    $display("port b test done");
    wr(pafs_pkg::OFS_B_FSL, 32'h20);
    wr(pafs_pkg::OFS_B_ALT, 32'h20);
    wr(pafs_pkg::OFS_CONFIG, 32'h1);
    wr(pafs_pkg::OFS_CONFIG, 32'h3);
    rd(pafs_pkg::OFS_CONFIG, 32'h1, 1'b0);
    cmp <= 1'b1;
    wr(pafs_pkg::OFS_C_DIR, 32'h0);
    wr(pafs_pkg::OFS_C_FSL, 32'h04);
    wr(pafs_pkg::OFS_C_ALT, 32'h0c);
    settle();
    chk({vc2, vb5, c_an[2]}, 3'b101);
    chk({c_out[3], c_oe[3]}, 2'b10);
    wr(pafs_pkg::OFS_CONFIG, 32'h0);
    settle();
    chk({eclk, a_oe[1]}, 2'b11);
    $display("package test done");
    wr(pafs_pkg::OFS_D_ALT, 32'h0);
    wr(pafs_pkg::OFS_D_OUT, 32'h0);
    settle();
    chk({d_out, d_oe, erst_b}, 3'b001);
    wr(pafs_pkg::OFS_D_OUT, 32'h1);
    settle();
    chk({d_out, d_oe, d_pin}, 3'b011);
    $display("port d test done");
    summarize();
  end
endmodule

// [inc/pafs_pkg.sv]
// shared constants for the port alternate function selector
package pafs_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_A_OUT = 8'h00;
  localparam logic [7:0] OFS_A_DIR = 8'h04;
  localparam logic [7:0] OFS_A_ALT = 8'h08;
  localparam logic [7:0] OFS_A_IN = 8'h0c;
  localparam logic [7:0] OFS_B_OUT = 8'h10;
  localparam logic [7:0] OFS_B_DIR = 8'h14;
  localparam logic [7:0] OFS_B_ALT = 8'h18;
  localparam logic [7:0] OFS_B_IN = 8'h1c;
  localparam logic [7:0] OFS_B_FSL = 8'h20;
  localparam logic [7:0] OFS_B_FSH = 8'h24;
  localparam logic [7:0] OFS_C_OUT = 8'h30;
  localparam logic [7:0] OFS_C_DIR = 8'h34;
  localparam logic [7:0] OFS_C_ALT = 8'h38;
  localparam logic [7:0] OFS_C_IN = 8'h3c;
  localparam logic [7:0] OFS_C_FSL = 8'h40;
  localparam logic [7:0] OFS_C_FSH = 8'h44;
  localparam logic [7:0] OFS_D_OUT = 8'h50;
  localparam logic [7:0] OFS_D_DIR = 8'h54;
  localparam logic [7:0] OFS_D_ALT = 8'h58;
  localparam logic [7:0] OFS_D_IN = 8'h5c;
  localparam logic [7:0] OFS_CONFIG = 8'h60;

  // ***************************************************************
  // reset values and field positions
  // ***************************************************************
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [7:0] FS_RST = 8'h00;
  localparam logic ALT_D_RST = 1'b1;
  localparam int unsigned CFG_PKG_LSB = 0;
  localparam int unsigned CFG_XTAL_BIT = 2;

  // ***************************************************************
  // package variants
  // ***************************************************************
  localparam logic [1:0] PKG_8 = 2'h0;
  localparam logic [1:0] PKG_20 = 2'h1;
  localparam logic [1:0] PKG_28 = 2'h2;
  localparam logic [1:0] PKG_RST = PKG_28;

endpackage

// [rtl/pafs_pin_stage.sv]
// registered pin output stage choosing port logic, alternate or override
`timescale 1ns/1ps
module pafs_pin_stage #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_gpio_out,
  input wire logic [WIDTH-1:0] i_gpio_dir_in,
  input wire logic [WIDTH-1:0] i_open_drain,
  input wire logic [WIDTH-1:0] i_alt_enable,
  input wire logic [WIDTH-1:0] i_alt_out,
  input wire logic [WIDTH-1:0] i_alt_oe_b,
  input wire logic [WIDTH-1:0] i_override,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe_b
);

  typedef struct packed {
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe_b;
  } pafs_stage_state_t;

  pafs_stage_state_t s;
  pafs_stage_state_t next_s;

  always_comb begin
    next_s = s;
    for (int i = 0; i < WIDTH; i++) begin
      if (i_override[i]) begin
        next_s.pin_out[i] = 1'b0;
        next_s.pin_oe_b[i] = 1'b1;
      end else if (i_alt_enable[i]) begin
        // peripheral owns both level and direction
        next_s.pin_out[i] = i_alt_out[i];
        next_s.pin_oe_b[i] = i_alt_oe_b[i];
      end else begin
        // open drain pins only ever pull low
        next_s.pin_out[i] = i_open_drain[i] ? 1'b0 : i_gpio_out[i];
        next_s.pin_oe_b[i] = i_gpio_dir_in[i] | (i_open_drain[i] & i_gpio_out[i]);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s.pin_out <= '0;
      s.pin_oe_b <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign o_pin_out = s.pin_out;
  assign o_pin_oe_b = s.pin_oe_b;

endmodule

// [rtl/pafs_port_mux.sv]
// port alternate function selector with apb register file
`timescale 1ns/1ps
module pafs_port_mux (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_port_a_pin,
  output logic [7:0] o_port_a_out,
  output logic [7:0] o_port_a_oe_b,
  input wire logic [7:0] i_port_b_pin,
  output logic [7:0] o_port_b_out,
  output logic [7:0] o_port_b_oe_b,
  input wire logic [7:0] i_port_c_pin,
  output logic [7:0] o_port_c_out,
  output logic [7:0] o_port_c_oe_b,
  input wire logic i_port_d_pin,
  output logic o_port_d_out,
  output logic o_port_d_oe_b,
  input wire logic i_crystal_enable,
  input wire logic i_timer_zero_output,
  input wire logic i_timer_zero_complement_mode,
  input wire logic i_timer_one_output,
  input wire logic i_timer_one_complement_mode,
  input wire logic i_uart_driver_enable,
  input wire logic i_uart_transmit,
  input wire logic i_comparator_output,
  input wire logic i_reset_drive,
  output logic o_timer_zero_input,
  output logic o_timer_one_input,
  output logic o_uart_clear_to_send,
  output logic o_uart_receive,
  output logic o_ext_clock_input,
  output logic o_ext_reset_b,
  output logic [7:0] o_port_b_analog,
  output logic [7:0] o_port_c_analog,
  output logic o_vref_on_port_b5,
  output logic o_vref_on_port_c2,
  output logic o_crystal_pins
);

  typedef struct packed {
    logic [7:0] out_a, dir_a, alt_a;
    logic [7:0] out_b, dir_b, alt_b, fsl_b, fsh_b;
    logic [7:0] out_c, dir_c, alt_c, fsl_c, fsh_c;
    logic out_d, dir_d, alt_d;
    logic [1:0] pkg;
    logic [31:0] prdata;
    logic ack;
    logic slverr;
    logic t0_in, t1_in, cts, rx, clk_in, rst_b;
    logic [7:0] ana_b, ana_c;
    logic vref_b5, vref_c2, xtal;
  } pafs_state_t;

  pafs_state_t s;
  pafs_state_t next_s;

  logic [7:0] sync_a, sync_b, sync_c;
  logic sync_d;
  logic [7:0] alt_out_a, alt_oe_b_a, alt_out_b, alt_oe_b_b, alt_out_c, alt_oe_b_c;
  logic alt_out_d, alt_oe_b_d;
  logic [7:0] ovr_a;
  logic setup, access;

  // ***************************************************************
  // pin input synchronisers
  // ***************************************************************
  pafs_sync #(.WIDTH(25)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_port_d_pin, i_port_c_pin, i_port_b_pin, i_port_a_pin}),
    .o_sync({sync_d, sync_c, sync_b, sync_a})
  );

  // ***************************************************************
  // alternate function routing
  // ***************************************************************
  always_comb begin
    // crystal pins are lost to the port whatever the settings
    ovr_a = {6'h00, {2{i_crystal_enable}}};
    // port A: no function-set bits, enable connects directly
    alt_out_a = 8'h00;
    alt_oe_b_a = 8'hff;
    alt_out_a[0] = ~i_timer_zero_output;
    alt_oe_b_a[0] = ~i_timer_zero_complement_mode;
    alt_out_a[1] = i_timer_zero_output;
    alt_oe_b_a[1] = (s.pkg == pafs_pkg::PKG_8);
    alt_out_a[2] = i_uart_driver_enable;
    alt_oe_b_a[2] = 1'b0;
    alt_out_a[5] = i_uart_transmit;
    alt_oe_b_a[5] = 1'b0;
    alt_out_a[6] = ~i_timer_one_output;
    alt_oe_b_a[6] = ~i_timer_one_complement_mode;
    alt_out_a[7] = i_timer_one_output;
    alt_oe_b_a[7] = 1'b0;
    // port B: analog selections leave the pin undriven; function_set_high unused
    alt_out_b = 8'h00;
    alt_oe_b_b = 8'hff;
    // port C: only bit 3 with set bit 0 drives (comparator)
    alt_out_c = 8'h00;
    alt_oe_b_c = 8'hff;
    alt_out_c[3] = i_comparator_output;
    alt_oe_b_c[3] = s.fsl_c[3];
    // port D: open drain reset output
    alt_out_d = 1'b0;
    alt_oe_b_d = ~i_reset_drive;
  end

  // ***************************************************************
  // registered pin outputs
  // ***************************************************************
  pafs_pin_stage #(.WIDTH(8)) u_stage_a (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_gpio_out(s.out_a), .i_gpio_dir_in(s.dir_a),
    .i_open_drain(8'h00), .i_alt_enable(s.alt_a), .i_alt_out(alt_out_a), .i_alt_oe_b(alt_oe_b_a),
    .i_override(ovr_a), .o_pin_out(o_port_a_out), .o_pin_oe_b(o_port_a_oe_b)
  );

  pafs_pin_stage #(.WIDTH(8)) u_stage_b (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_gpio_out(s.out_b), .i_gpio_dir_in(s.dir_b),
    .i_open_drain(8'h00), .i_alt_enable(s.alt_b), .i_alt_out(alt_out_b), .i_alt_oe_b(alt_oe_b_b),
    .i_override(8'h00), .o_pin_out(o_port_b_out), .o_pin_oe_b(o_port_b_oe_b)
  );

  pafs_pin_stage #(.WIDTH(8)) u_stage_c (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_gpio_out(s.out_c), .i_gpio_dir_in(s.dir_c),
    .i_open_drain(8'h00), .i_alt_enable(s.alt_c), .i_alt_out(alt_out_c), .i_alt_oe_b(alt_oe_b_c),
    .i_override(8'h00), .o_pin_out(o_port_c_out), .o_pin_oe_b(o_port_c_oe_b)
  );

  // port D bit 0 is an output-only open drain in port mode
  pafs_pin_stage #(.WIDTH(1)) u_stage_d (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_gpio_out(s.out_d), .i_gpio_dir_in(1'b0),
    .i_open_drain(1'b1), .i_alt_enable(s.alt_d), .i_alt_out(alt_out_d), .i_alt_oe_b(alt_oe_b_d),
    .i_override(1'b0), .o_pin_out(o_port_d_out), .o_pin_oe_b(o_port_d_oe_b)
  );

  // ***************************************************************
  // register file and peripheral inputs
  // ***************************************************************
  assign setup = i_psel & i_penable & ~s.ack;
  assign access = i_psel & i_penable & s.ack;

  always_comb begin
    next_s = s;
    next_s.ack = setup;
    if (setup) begin
      next_s.slverr = 1'b0;
      case (i_paddr)
        pafs_pkg::OFS_A_OUT: next_s.prdata = {24'h000000, s.out_a};
        pafs_pkg::OFS_A_DIR: next_s.prdata = {24'h000000, s.dir_a};
        pafs_pkg::OFS_A_ALT: next_s.prdata = {24'h000000, s.alt_a};
        pafs_pkg::OFS_A_IN: next_s.prdata = {24'h000000, sync_a};
        pafs_pkg::OFS_B_OUT: next_s.prdata = {24'h000000, s.out_b};
        pafs_pkg::OFS_B_DIR: next_s.prdata = {24'h000000, s.dir_b};
        pafs_pkg::OFS_B_ALT: next_s.prdata = {24'h000000, s.alt_b};
        pafs_pkg::OFS_B_IN: next_s.prdata = {24'h000000, sync_b};
        pafs_pkg::OFS_B_FSL: next_s.prdata = {24'h000000, s.fsl_b};
        pafs_pkg::OFS_B_FSH: next_s.prdata = {24'h000000, s.fsh_b};
        pafs_pkg::OFS_C_OUT: next_s.prdata = {24'h000000, s.out_c};
        pafs_pkg::OFS_C_DIR: next_s.prdata = {24'h000000, s.dir_c};
        pafs_pkg::OFS_C_ALT: next_s.prdata = {24'h000000, s.alt_c};
        pafs_pkg::OFS_C_IN: next_s.prdata = {24'h000000, sync_c};
        pafs_pkg::OFS_C_FSL: next_s.prdata = {24'h000000, s.fsl_c};
        pafs_pkg::OFS_C_FSH: next_s.prdata = {24'h000000, s.fsh_c};
        pafs_pkg::OFS_D_OUT: next_s.prdata = {31'h00000000, s.out_d};
        pafs_pkg::OFS_D_DIR: next_s.prdata = {31'h00000000, s.dir_d};
        pafs_pkg::OFS_D_ALT: next_s.prdata = {31'h00000000, s.alt_d};
        pafs_pkg::OFS_D_IN: next_s.prdata = {31'h00000000, sync_d};
        pafs_pkg::OFS_CONFIG: next_s.prdata = {29'h00000000, s.xtal, s.pkg};
        default: begin
          next_s.prdata = 32'h00000000;
          next_s.slverr = 1'b1;
        end
      endcase
    end else if (access) begin
      next_s.slverr = 1'b0;
      next_s.prdata = 32'h00000000;
    end
    // writes take effect on the edge that completes the access phase
    if (access && i_pwrite) begin
      case (i_paddr)
        pafs_pkg::OFS_A_OUT: next_s.out_a = i_pwdata[7:0];
        pafs_pkg::OFS_A_DIR: next_s.dir_a = i_pwdata[7:0];
        pafs_pkg::OFS_A_ALT: next_s.alt_a = i_pwdata[7:0];
        pafs_pkg::OFS_B_OUT: next_s.out_b = i_pwdata[7:0];
        pafs_pkg::OFS_B_DIR: next_s.dir_b = i_pwdata[7:0];
        pafs_pkg::OFS_B_ALT: next_s.alt_b = i_pwdata[7:0];
        pafs_pkg::OFS_B_FSL: next_s.fsl_b = i_pwdata[7:0];
        pafs_pkg::OFS_B_FSH: next_s.fsh_b = i_pwdata[7:0];
        pafs_pkg::OFS_C_OUT: next_s.out_c = i_pwdata[7:0];
        pafs_pkg::OFS_C_DIR: next_s.dir_c = i_pwdata[7:0];
        pafs_pkg::OFS_C_ALT: next_s.alt_c = i_pwdata[7:0];
        pafs_pkg::OFS_C_FSL: next_s.fsl_c = i_pwdata[7:0];
        pafs_pkg::OFS_C_FSH: next_s.fsh_c = i_pwdata[7:0];
        pafs_pkg::OFS_D_OUT: next_s.out_d = i_pwdata[0];
        pafs_pkg::OFS_D_DIR: next_s.dir_d = i_pwdata[0];
        pafs_pkg::OFS_D_ALT: next_s.alt_d = i_pwdata[0];
        pafs_pkg::OFS_CONFIG: begin
          if (i_pwdata[1:0] != 2'h3) begin
            next_s.pkg = i_pwdata[1:0];
          end
        end
        default: next_s.pkg = s.pkg;
      endcase
    end
    // peripheral inputs fed from synchronised pins
    next_s.xtal = i_crystal_enable;
    next_s.t0_in = s.alt_a[0] & ~i_crystal_enable & ~i_timer_zero_complement_mode & sync_a[0];
    next_s.t1_in = s.alt_a[6] & ~i_timer_one_complement_mode & sync_a[6];
    next_s.cts = s.alt_a[3] & sync_a[3];
    next_s.rx = s.alt_a[4] ? sync_a[4] : 1'b1;
    if (s.pkg == pafs_pkg::PKG_8) begin
      next_s.clk_in = s.alt_a[1] & ~i_crystal_enable & sync_a[1];
    end else begin
      next_s.clk_in = s.alt_b[3] & ~s.fsl_b[3] & sync_b[3];
    end
    next_s.rst_b = s.alt_d ? sync_d : 1'b1;
    next_s.ana_b = s.alt_b & s.fsl_b & 8'h3f;
    if (s.pkg != pafs_pkg::PKG_28) begin
      next_s.ana_b[5] = 1'b0;
    end
    next_s.ana_c = s.alt_c & s.fsl_c & 8'h07;
    next_s.vref_b5 = (s.pkg == pafs_pkg::PKG_28) & s.alt_b[5] & s.fsl_b[5];
    next_s.vref_c2 = (s.pkg == pafs_pkg::PKG_20) & s.alt_c[2] & s.fsl_c[2];
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.dir_a <= pafs_pkg::DIR_RST;
      s.dir_b <= pafs_pkg::DIR_RST;
      s.dir_c <= pafs_pkg::DIR_RST;
      s.dir_d <= 1'b1;
      s.alt_d <= pafs_pkg::ALT_D_RST;
      s.pkg <= pafs_pkg::PKG_RST;
      s.rx <= 1'b1;
      s.rst_b <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.ack;
  assign o_pslverr = s.slverr;
  assign o_timer_zero_input = s.t0_in;
  assign o_timer_one_input = s.t1_in;
  assign o_uart_clear_to_send = s.cts;
  assign o_uart_receive = s.rx;
  assign o_ext_clock_input = s.clk_in;
  assign o_ext_reset_b = s.rst_b;
  assign o_port_b_analog = s.ana_b;
  assign o_port_c_analog = s.ana_c;
  assign o_vref_on_port_b5 = s.vref_b5;
  assign o_vref_on_port_c2 = s.vref_c2;
  assign o_crystal_pins = s.xtal;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence s_b3_clock_sel;
    s.pkg != pafs_pkg::PKG_8 && s.alt_b[3] && !s.fsl_b[3];
  endsequence

  // skip the release edge, where the pin stage still shows its reset level
  sequence s_d_reset_drive;
    $past(i_rst_b) && s.alt_d && i_reset_drive;
  endsequence

  a_crystal_pins_off: assert property (i_crystal_enable |=> o_port_a_oe_b[1:0] == 2'b11)
    else $error("crystal pins still driven");
  a_b3_clock_route: assert property (s_b3_clock_sel ##0 $stable(s.alt_b) |=> o_ext_clock_input == $past(sync_b[3]))
    else $error("clock input not from port b bit 3");
  a_a1_clock_route: assert property (s.pkg == pafs_pkg::PKG_8 && s.alt_a[1] && !i_crystal_enable |=> o_ext_clock_input == $past(sync_a[1]))
    else $error("clock input not from port a bit 1");
  a_d_reset_pull: assert property (s_d_reset_drive |=> !o_port_d_oe_b && !o_port_d_out)
    else $error("reset pin not pulled low");
  a_a0_complement: assert property (s.alt_a[0] && i_timer_zero_complement_mode && !i_crystal_enable |=> !o_port_a_oe_b[0] && o_port_a_out[0] == !$past(i_timer_zero_output))
    else $error("timer zero complement not on port a bit 0");
  a_a5_transmit: assert property (s.alt_a[5] |=> !o_port_a_oe_b[5] && o_port_a_out[5] == $past(i_uart_transmit))
    else $error("uart transmit not on port a bit 5");
  a_b_reserved_off: assert property (s.alt_b[7:6] != 2'b00 |=> o_port_b_oe_b[7:6] == 2'b11 && o_port_b_analog[7:6] == 2'b00)
    else $error("reserved port b pin driven");
  a_b0_analog_sel: assert property (s.alt_b[0] && s.fsl_b[0] |=> o_port_b_analog[0] && o_port_b_oe_b[0])
    else $error("port b bit 0 analog not selected");
  a_vref_by_pkg: assert property (o_vref_on_port_b5 |-> !o_vref_on_port_c2 && $past(s.pkg) == pafs_pkg::PKG_28)
    else $error("voltage reference on wrong pin");
  a_gpio_pass: assert property (!s.alt_c[4] |=> o_port_c_out[4] == $past(s.out_c[4]) && o_port_c_oe_b[4] == $past(s.dir_c[4]))
    else $error("port c bit 4 not under port registers");
  a_fsh_ignored: assert property (s.alt_c[3] && !s.fsl_c[3] |=> !o_port_c_oe_b[3] && o_port_c_out[3] == $past(i_comparator_output))
    else $error("comparator output not on port c bit 3");

endmodule

// [rtl/pafs_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pafs_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pafs_sync_state_t;

  pafs_sync_state_t s;
  pafs_sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.stage1 = i_async;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_sync = s.stage2;

endmodule
